// [include/tsa_consts.svh]
// Constants for the thermometer scratchpad and alarm block
`ifndef TSA_CONSTS_SVH
`define TSA_CONSTS_SVH

// Function and search command codes
`define TSA_CMD_CONVERT 8'h44
`define TSA_CMD_COPY 8'h48
`define TSA_CMD_READ_PWR 8'hb4
`define TSA_CMD_RECALL 8'hb8
`define TSA_CMD_WRITE_PAD 8'h4e
`define TSA_CMD_READ_PAD 8'hbe
`define TSA_CMD_ALARM_SEARCH 8'hec

// Scratchpad byte offsets
`define TSA_OFS_TEMP_LO 4'h0
`define TSA_OFS_TEMP_HI 4'h1
`define TSA_OFS_UPPER 4'h2
`define TSA_OFS_LOWER 4'h3
`define TSA_OFS_CFG 4'h4
`define TSA_OFS_RSVD_A 4'h5
`define TSA_OFS_RSVD_B 4'h6
`define TSA_OFS_RSVD_C 4'h7
`define TSA_OFS_CRC 4'h8
`define TSA_PAD_BYTES 9
`define TSA_PAD_BITS 7'h48

// Field positions and fixed reserved values
`define TSA_CFG_RES_LSB 5
`define TSA_CFG_RES_MSB 6
`define TSA_CMP_LSB 4
`define TSA_CMP_MSB 11
`define TSA_RSVD_BYTE 8'hff
`define TSA_CFG_RSVD_LO 5'h1f
`define TSA_CFG_RSVD_HI 1'b1

// Reset values and CRC polynomial
`define TSA_TEMP_RESET 16'h0550
`define TSA_UPPER_DEFAULT 8'h7f
`define TSA_LOWER_DEFAULT 8'h80
`define TSA_RES_DEFAULT 2'h3
`define TSA_CRC_POLY 8'h8c

// Nonvolatile word addresses
`define TSA_NV_UPPER 2'h0
`define TSA_NV_LOWER 2'h1
`define TSA_NV_CFG 2'h2
`define TSA_NV_WORDS 3

// Timing
`define TSA_CLK_MHZ 100
`define TSA_T_CONV_MS 750
`define TSA_T_NVWR_MS 10
`define TSA_CONV_CYCLES (`TSA_T_CONV_MS * 1000 * `TSA_CLK_MHZ)
`define TSA_NVWR_CYCLES (`TSA_T_NVWR_MS * 1000 * `TSA_CLK_MHZ)

`endif

// [include/tsa_pkg.sv]
// Types for the thermometer scratchpad and alarm block
package tsa_pkg;

    typedef enum logic [2:0] {
        ST_BOOT,
        ST_IDLE,
        ST_RECALL,
        ST_CONV,
        ST_COPY
    } tsa_state_e;

    typedef enum logic [1:0] {
        RD_NONE,
        RD_PAD,
        RD_POWER,
        RD_STATUS
    } tsa_rd_e;

endpackage : tsa_pkg

// [src/tsa_nv_store.sv]
// Nonvolatile store for limits and configuration
`timescale 1ns/1ps
`include "tsa_consts.svh"
module tsa_nv_store (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Write port
    input wire logic we,
    input wire logic [1:0] waddr,
    input wire logic [7:0] wdata,
    // Read port
    input wire logic [1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:`TSA_NV_WORDS-1];
    logic [7:0] next_mem [0:`TSA_NV_WORDS-1];
    logic [7:0] next_rdata;

    always_comb begin
        for (int i = 0; i < `TSA_NV_WORDS; i++) begin
            next_mem[i] = mem[i];
        end
        if (we && waddr < 2'h3) begin
            next_mem[waddr] = wdata;
        end
        next_rdata = (raddr < 2'h3) ? mem[raddr] : 8'h00;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem[`TSA_NV_UPPER] <= `TSA_UPPER_DEFAULT;
            mem[`TSA_NV_LOWER] <= `TSA_LOWER_DEFAULT;
            mem[`TSA_NV_CFG] <= {`TSA_CFG_RSVD_HI, `TSA_RES_DEFAULT, `TSA_CFG_RSVD_LO};
            rdata <= 8'h00;
        end else begin
            for (int i = 0; i < `TSA_NV_WORDS; i++) begin
                mem[i] <= next_mem[i];
            end
            rdata <= next_rdata;
        end
    end
endmodule : tsa_nv_store

// [src/tsa_thermometer_scratchpad_alarm.sv]
// Scratchpad, alarm, nonvolatile and identity logic of the thermometer
`timescale 1ns/1ps
`include "tsa_consts.svh"
module tsa_thermometer_scratchpad_alarm #(
    parameter int unsigned CONV_CYCLES = `TSA_CONV_CYCLES,
    parameter int unsigned NVWR_CYCLES = `TSA_NVWR_CYCLES,
    // Arbitrary value
    parameter logic [7:0] FAMILY_CODE = 8'h5a,
    // Arbitrary value
    parameter logic [47:0] SERIAL_NUMBER = 48'h0123_4567_89ab
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Commands from the line framer
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    // Buffer-load data bytes
    input wire logic wr_valid,
    input wire logic [7:0] wr_byte,
    // Read time slots
    input wire logic slot_req,
    output logic slot_ack,
    output logic slot_bit,
    // Converter sample
    input wire logic [15:0] temp_sample,
    // Supply sense pin
    input wire logic vdd_sense,
    // Status
    output logic alarm_flag,
    output logic search_join,
    output logic busy,
    output logic parasite_mode,
    output logic [63:0] rom_code
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    tsa_pkg::tsa_state_e st, next_st;
    tsa_pkg::tsa_rd_e rd_mode, next_rd_mode;
    logic [31:0] tmr, next_tmr;
    logic [6:0] bit_idx, next_bit_idx;
    logic [1:0] wr_idx, next_wr_idx;
    logic [15:0] temp, next_temp;
    logic [7:0] upper_alarm_limit, next_upper_alarm_limit;
    logic [7:0] lower_alarm_limit, next_lower_alarm_limit;
    logic resolution_sel_high, next_resolution_sel_high;
    logic resolution_sel_low, next_resolution_sel_low;
    logic next_alarm_flag, next_search_join, next_busy;
    logic next_slot_ack, next_slot_bit;
    logic [7:0] crc_byte, next_crc_byte;
    logic [63:0] next_rom_code;
    logic vdd_meta, vdd_sync, next_parasite_mode;
    logic [7:0] pad [0:`TSA_PAD_BYTES-1];
    logic [71:0] pad_bits;
    logic [31:0] conv_lim;
    logic conv_end, cmd_take, wr_take;
    logic nv_we;
    logic [1:0] nv_waddr, nv_raddr;
    logic [7:0] nv_wdata, nv_rdata;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [7:0] tsa_crc8(input logic [63:0] d, input int n);
        logic [7:0] c;
        logic fb;
        c = 8'h00;
        for (int i = 0; i < 64; i++) begin
            if (i < n) begin
                fb = c[0] ^ d[i];
                c = {1'b0, c[7:1]};
                if (fb) begin
                    c = c ^ `TSA_CRC_POLY;
                end
            end
        end
        return c;
    endfunction : tsa_crc8

    function automatic logic tsa_alarm(input logic [15:0] t, input logic [7:0] hi,
                                       input logic [7:0] lo);
        logic signed [7:0] s;
        s = signed'(t[`TSA_CMP_MSB:`TSA_CMP_LSB]);
        return (s <= signed'(lo)) || (s > signed'(hi));
    endfunction : tsa_alarm

    ////////////////////////////////////////////////////////////////////////
    // Scratchpad image

    always_comb begin
        pad[`TSA_OFS_TEMP_LO] = temp[7:0];
        pad[`TSA_OFS_TEMP_HI] = temp[15:8];
        pad[`TSA_OFS_UPPER] = upper_alarm_limit;
        pad[`TSA_OFS_LOWER] = lower_alarm_limit;
        pad[`TSA_OFS_CFG] = {`TSA_CFG_RSVD_HI, resolution_sel_high, resolution_sel_low,
                             `TSA_CFG_RSVD_LO};
        pad[`TSA_OFS_RSVD_A] = `TSA_RSVD_BYTE;
        pad[`TSA_OFS_RSVD_B] = `TSA_RSVD_BYTE;
        pad[`TSA_OFS_RSVD_C] = `TSA_RSVD_BYTE;
        pad[`TSA_OFS_CRC] = crc_byte;
    end

    for (genvar g = 0; g < `TSA_PAD_BYTES; g++) begin : g_pad
        assign pad_bits[g*8 +: 8] = pad[g];
    end

    ////////////////////////////////////////////////////////////////////////
    // Control decode

    assign conv_lim = 32'(CONV_CYCLES) >> (2'h3 - {resolution_sel_high, resolution_sel_low});
    assign conv_end = (st == tsa_pkg::ST_CONV) && (tmr == conv_lim - 32'h1);
    assign cmd_take = cmd_valid && (st == tsa_pkg::ST_IDLE);
    assign wr_take = wr_valid && (st == tsa_pkg::ST_IDLE) && (wr_idx != 2'h3);
    assign nv_we = (st == tsa_pkg::ST_COPY) && (tmr < 32'h3);
    assign nv_waddr = tmr[1:0];
    assign nv_wdata = pad[4'(tmr[1:0]) + `TSA_OFS_UPPER];
    assign nv_raddr = (tmr[1:0] == 2'h3) ? `TSA_NV_UPPER : tmr[1:0];

    tsa_nv_store u_nv (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .we(nv_we),
        .waddr(nv_waddr),
        .wdata(nv_wdata),
        .raddr(nv_raddr),
        .rdata(nv_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control state

    always_comb begin
        next_st = st;
        next_rd_mode = rd_mode;
        next_tmr = tmr;
        next_bit_idx = bit_idx;
        next_wr_idx = wr_idx;
        next_temp = temp;
        next_upper_alarm_limit = upper_alarm_limit;
        next_lower_alarm_limit = lower_alarm_limit;
        next_resolution_sel_high = resolution_sel_high;
        next_resolution_sel_low = resolution_sel_low;
        next_alarm_flag = alarm_flag;
        next_search_join = search_join;
        next_slot_ack = 1'b0;
        next_slot_bit = slot_bit;
        unique case (st)
            tsa_pkg::ST_BOOT, tsa_pkg::ST_RECALL: begin
                next_tmr = tmr + 32'h1;
                unique case (tmr[1:0])
                    2'h0: ;
                    2'h1: next_upper_alarm_limit = nv_rdata;
                    2'h2: next_lower_alarm_limit = nv_rdata;
                    2'h3: begin
                        next_resolution_sel_high = nv_rdata[`TSA_CFG_RES_MSB];
                        next_resolution_sel_low = nv_rdata[`TSA_CFG_RES_LSB];
                        next_st = tsa_pkg::ST_IDLE;
                        next_tmr = 32'h0;
                    end
                endcase
            end
            tsa_pkg::ST_CONV: begin
                next_tmr = tmr + 32'h1;
                if (conv_end) begin
                    next_temp = temp_sample;
                    next_alarm_flag = tsa_alarm(temp_sample, upper_alarm_limit,
                                                lower_alarm_limit);
                    next_st = tsa_pkg::ST_IDLE;
                    next_tmr = 32'h0;
                end
            end
            tsa_pkg::ST_COPY: begin
                next_tmr = tmr + 32'h1;
                if (tmr == 32'(NVWR_CYCLES) - 32'h1) begin
                    next_st = tsa_pkg::ST_IDLE;
                    next_tmr = 32'h0;
                end
            end
            tsa_pkg::ST_IDLE: begin
                if (cmd_take) begin
                    next_rd_mode = tsa_pkg::RD_NONE;
                    next_wr_idx = 2'h3;
                    next_search_join = 1'b0;
                    unique case (cmd_code)
                        `TSA_CMD_CONVERT: begin
                            next_st = tsa_pkg::ST_CONV;
                            next_rd_mode = tsa_pkg::RD_STATUS;
                        end
                        `TSA_CMD_COPY: next_st = tsa_pkg::ST_COPY;
                        `TSA_CMD_RECALL: begin
                            next_st = tsa_pkg::ST_RECALL;
                            next_rd_mode = tsa_pkg::RD_STATUS;
                        end
                        `TSA_CMD_READ_PAD: begin
                            next_rd_mode = tsa_pkg::RD_PAD;
                            next_bit_idx = 7'h0;
                        end
                        `TSA_CMD_READ_PWR: next_rd_mode = tsa_pkg::RD_POWER;
                        `TSA_CMD_WRITE_PAD: next_wr_idx = 2'h0;
                        `TSA_CMD_ALARM_SEARCH: next_search_join = alarm_flag;
                        default: ;
                    endcase
                end else if (wr_take) begin
                    next_wr_idx = wr_idx + 2'h1;
                    unique case (wr_idx)
                        2'h0: next_upper_alarm_limit = wr_byte;
                        2'h1: next_lower_alarm_limit = wr_byte;
                        2'h2: begin
                            next_resolution_sel_high = wr_byte[`TSA_CFG_RES_MSB];
                            next_resolution_sel_low = wr_byte[`TSA_CFG_RES_LSB];
                        end
                        2'h3: ;
                    endcase
                end
            end
            default: next_st = tsa_pkg::ST_IDLE;
        endcase
        if (slot_req) begin
            next_slot_ack = 1'b1;
            unique case (rd_mode)
                tsa_pkg::RD_PAD: begin
                    next_slot_bit = (bit_idx < `TSA_PAD_BITS) ? pad_bits[bit_idx] : 1'b1;
                    if (bit_idx < `TSA_PAD_BITS) begin
                        next_bit_idx = bit_idx + 7'h1;
                    end
                end
                tsa_pkg::RD_POWER: next_slot_bit = !parasite_mode;
                tsa_pkg::RD_STATUS: next_slot_bit = (st == tsa_pkg::ST_IDLE);
                tsa_pkg::RD_NONE: next_slot_bit = 1'b1;
            endcase
        end
        next_busy = (next_st != tsa_pkg::ST_IDLE);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= tsa_pkg::ST_BOOT;
            rd_mode <= tsa_pkg::RD_NONE;
            tmr <= 32'h0;
            bit_idx <= 7'h0;
            wr_idx <= 2'h3;
            temp <= `TSA_TEMP_RESET;
            upper_alarm_limit <= `TSA_UPPER_DEFAULT;
            lower_alarm_limit <= `TSA_LOWER_DEFAULT;
            resolution_sel_high <= 1'(`TSA_RES_DEFAULT >> 1);
            resolution_sel_low <= 1'(`TSA_RES_DEFAULT & 2'h1);
            alarm_flag <= 1'b0;
            search_join <= 1'b0;
            slot_ack <= 1'b0;
            slot_bit <= 1'b1;
            busy <= 1'b1;
        end else begin
            st <= next_st;
            rd_mode <= next_rd_mode;
            tmr <= next_tmr;
            bit_idx <= next_bit_idx;
            wr_idx <= next_wr_idx;
            temp <= next_temp;
            upper_alarm_limit <= next_upper_alarm_limit;
            lower_alarm_limit <= next_lower_alarm_limit;
            resolution_sel_high <= next_resolution_sel_high;
            resolution_sel_low <= next_resolution_sel_low;
            alarm_flag <= next_alarm_flag;
            search_join <= next_search_join;
            slot_ack <= next_slot_ack;
            slot_bit <= next_slot_bit;
            busy <= next_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Identity code, scratchpad CRC and supply sense

    always_comb begin
        next_crc_byte = tsa_crc8(pad_bits[63:0], 64);
        next_rom_code = {tsa_crc8({8'h00, SERIAL_NUMBER, FAMILY_CODE}, 56),
                         SERIAL_NUMBER, FAMILY_CODE};
        next_parasite_mode = !vdd_sync;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            crc_byte <= 8'h00;
            rom_code <= 64'h0;
            vdd_meta <= 1'b1;
            vdd_sync <= 1'b1;
            parasite_mode <= 1'b0;
        end else begin
            crc_byte <= next_crc_byte;
            rom_code <= next_rom_code;
            vdd_meta <= vdd_sense;
            vdd_sync <= vdd_meta;
            parasite_mode <= next_parasite_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_alarm_eval: assert property (
        conv_end |=> alarm_flag == tsa_alarm(temp, upper_alarm_limit, lower_alarm_limit))
        else $error("alarm flag differs from limit comparison");

    a_alarm_hold: assert property (
        !conv_end |=> $stable(alarm_flag))
        else $error("alarm flag changed outside conversion end");

    a_search_join: assert property (
        cmd_take && cmd_code == `TSA_CMD_ALARM_SEARCH |=> search_join == $past(alarm_flag))
        else $error("alarm search participation wrong");

    a_temp_ro: assert property (
        !conv_end |=> $stable(temp))
        else $error("temperature bytes changed without conversion");

    a_rsvd_ones: assert property (
        slot_req && rd_mode == tsa_pkg::RD_PAD && bit_idx >= 7'h28 && bit_idx < 7'h40
        |=> slot_ack && slot_bit)
        else $error("reserved byte bit read as zero");

    a_crc_track: assert property (
        reset_n |=> crc_byte == tsa_crc8($past(pad_bits[63:0]), 64))
        else $error("scratchpad CRC stale");

    a_copy_write: assert property (
        cmd_take && cmd_code == `TSA_CMD_COPY |=> nv_we ##1 nv_we ##1 nv_we ##1 !nv_we)
        else $error("nonvolatile copy did not write three bytes");

    a_recall_status: assert property (
        cmd_take && cmd_code == `TSA_CMD_RECALL |=> busy [*4] ##1 !busy)
        else $error("reload did not finish in four cycles");

    a_boot_load: assert property (
        st == tsa_pkg::ST_BOOT |-> ##[1:4] st == tsa_pkg::ST_IDLE)
        else $error("power-up load did not finish");

    a_write_order: assert property (
        wr_take && wr_idx == 2'h0 |=> upper_alarm_limit == $past(wr_byte))
        else $error("first buffer-load byte not stored as upper limit");

    a_read_first: assert property (
        slot_req && rd_mode == tsa_pkg::RD_PAD && bit_idx == 7'h0 |=> slot_bit == $past(temp[0]))
        else $error("buffer read does not start at byte zero bit zero");

    a_power_bit: assert property (
        slot_req && rd_mode == tsa_pkg::RD_POWER |=> slot_bit == !$past(parasite_mode))
        else $error("power query bit wrong");

    a_rom_layout: assert property (
        st == tsa_pkg::ST_IDLE |-> rom_code[7:0] == FAMILY_CODE
        && rom_code[63:56] == tsa_crc8(rom_code, 56))
        else $error("identity code layout wrong");

    c_conv_alarm: cover property (conv_end ##1 alarm_flag);
    c_copy_done: cover property (st == tsa_pkg::ST_COPY ##1 st == tsa_pkg::ST_IDLE);
    c_pad_read_end: cover property (slot_ack && rd_mode == tsa_pkg::RD_PAD
                                    && bit_idx == `TSA_PAD_BITS);
    c_search_join: cover property (search_join);

endmodule : tsa_thermometer_scratchpad_alarm

// [dv/tsa_master_model.sv]
// Bus master model driving command, data and read-slot strobes
`timescale 1ns/1ps
module tsa_master_model (
    // Clock
    input wire logic core_clk,
    // Device status
    input wire logic busy,
    input wire logic slot_ack,
    input wire logic slot_bit,
    // Requests
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic wr_valid,
    output logic [7:0] wr_byte,
    output logic slot_req
);
    // Waits that ran out of their bound
    int tmo = 0;

    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        wr_valid = 1'b0;
        wr_byte = 8'h00;
        slot_req = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wait until idle, bounded
    task automatic idle(output int n);
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= 2000) tmo++;
    endtask : idle

    // Quiet while busy, then one command strobe
    task automatic cmd(input logic [7:0] code);
        int w;
        idle(w);
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_code = code;
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b0;
        cmd_code = ~code;
    endtask : cmd

    // Whole data byte, framer already assembled it LSB first
    task automatic wb(input logic [7:0] d);
        @(posedge core_clk);
        #1;
        wr_valid = 1'b1;
        wr_byte = d;
        @(posedge core_clk);
        #1;
        wr_valid = 1'b0;
        wr_byte = ~d;
    endtask : wb

    // One read slot; unknown if no acknowledge came
    task automatic slot(output logic b);
        @(posedge core_clk);
        #1;
        slot_req = 1'b1;
        @(posedge core_clk);
        #1;
        slot_req = 1'b0;
        b = (slot_ack === 1'b1) ? slot_bit : 1'bx;
    endtask : slot
endmodule : tsa_master_model

// [dv/testbench.sv]
// Self-checking bench for the thermometer scratchpad and alarm block
`timescale 1ns/1ps
module testbench;
    // Arbitrary value
    localparam logic [7:0] FAM = 8'h3c;
    // Arbitrary value
    localparam logic [47:0] SER = 48'h1122_3344_5566;
    logic core_clk;
    logic reset_n;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic wr_valid;
    logic [7:0] wr_byte;
    logic slot_req;
    logic slot_ack;
    logic slot_bit;
    logic [15:0] temp_sample;
    logic vdd_sense;
    logic alarm_flag;
    logic search_join;
    logic busy;
    logic parasite_mode;
    logic [63:0] rom_code;
    logic [71:0] p;
    logic b;
    int n;
    int miscompares = 0;
    int n_tests = 0;
    logic [15:0] temps [5] = '{16'h0190, 16'h01a0, 16'h0060, 16'h0050, 16'hff58};
    logic alarms [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

    tsa_thermometer_scratchpad_alarm #(.CONV_CYCLES(64), .NVWR_CYCLES(8),
        .FAMILY_CODE(FAM), .SERIAL_NUMBER(SER)) DUT (
        .core_clk(core_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .wr_valid(wr_valid), .wr_byte(wr_byte),
        .slot_req(slot_req), .slot_ack(slot_ack), .slot_bit(slot_bit),
        .temp_sample(temp_sample), .vdd_sense(vdd_sense), .alarm_flag(alarm_flag),
        .search_join(search_join), .busy(busy), .parasite_mode(parasite_mode),
        .rom_code(rom_code));

    tsa_master_model master (
        .core_clk(core_clk), .busy(busy), .slot_ack(slot_ack), .slot_bit(slot_bit),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .wr_valid(wr_valid),
        .wr_byte(wr_byte), .slot_req(slot_req));

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [7:0] crc8(input logic [71:0] d, input int nb);
        logic [7:0] c;
        logic fb;
        c = 8'h00;
        for (int i = 0; i < nb; i++) begin
            fb = c[0] ^ d[i];
            c = c >> 1;
            if (fb) c = c ^ 8'h8c;
        end
        return c;
    endfunction : crc8

    function automatic logic [71:0] pad(input logic [15:0] t, input logic [7:0] u,
                                        input logic [7:0] l, input logic [7:0] cfg);
        logic [63:0] d;
        d = {24'hffffff, cfg, l, u, t};
        return {crc8({8'h00, d}, 64), d};
    endfunction : pad

    task automatic chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic results;
        miscompares += master.tmo;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results

    task automatic idle(output int w);
        master.idle(w);
        if (w >= 2000) begin
            miscompares++;
            results();
        end
    endtask : idle

    task automatic rd(output logic [71:0] q);
        master.cmd(8'hbe);
        for (int i = 0; i < 72; i++) master.slot(q[i]);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and sequence
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        reset_n = 1'b0;
        temp_sample = 16'h0550;
        vdd_sense = 1'b1;
        repeat (20) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        idle(n);
        chk("rom", 72'(rom_code), 72'({crc8({16'h0, SER, FAM}, 56), SER, FAM}));
        rd(p);
        chk("pad_boot", p, pad(16'h0550, 8'h7f, 8'h80, 8'hff));
        for (int i = 0; i < 5; i++) begin
            master.cmd(8'h4e);
            master.wb(8'h19);
            master.wb(8'h05);
            master.wb({1'b0, i[1:0], 5'h00});
            master.wb(8'h00);
            temp_sample = temps[i];
            master.cmd(8'h44);
            idle(n);
            chk("conv_time", 72'(n), 72'(64 >> (3 - i % 4)));
            chk("alarm", 72'(alarm_flag), 72'(alarms[i]));
            master.cmd(8'hec);
            chk("search", 72'(search_join), 72'(alarms[i]));
        end
        rd(p);
        chk("pad_conv", p, pad(16'hff58, 8'h19, 8'h05, 8'h9f));
        master.cmd(8'h48);
        idle(n);
        chk("copy_time", 72'(n), 72'(8));
        master.cmd(8'h4e);
        master.wb(8'h01);
        master.wb(8'h02);
        master.wb(8'hff);
        master.cmd(8'hb8);
        master.slot(b);
        chk("recall_busy", 72'(b), 72'(0));
        idle(n);
        master.slot(b);
        chk("recall_done", 72'(b), 72'(1));
        rd(p);
        chk("pad_recall", p, pad(16'hff58, 8'h19, 8'h05, 8'h9f));
        master.cmd(8'hb4);
        master.slot(b);
        chk("pwr_ext", 72'(b), 72'(1));
        vdd_sense = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        chk("parasite", 72'(parasite_mode), 72'(1));
        master.cmd(8'hb4);
        master.slot(b);
        chk("pwr_par", 72'(b), 72'(0));
        results();
    end
endmodule : testbench
